// ==== core/ufs_top.sv ====
// Control and status logic of the two-channel serial port, one instance per channel.
//
// Our own choice: the plain strobed port.

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Transmit trigger at bits 7:6: empty, 4, 8 or 12 bytes.
// - Receive trigger at bits 5:4: 4, 8, 12 or 16 bytes.
// - Writing 1 to bit 2 empties transmit FIFO; bit self-clears.
// - Writing 1 to bit 1 empties receive FIFO; bit self-clears.
// - Bit 0 selects FIFO mode, else single holding registers.
// - Receive data below trigger, idle three character times, raises timeout interrupt.
// - Auto flow enable bit 4 makes hardware drive request-to-send.
// - Without auto flow, modem bit 0 set drives request_to_send_n low.
// - Status bit 2 is one when holding buffer and shifter both empty.
// - Status bit 1 is one while transmit holding buffer is empty.
// - Status bit 0 is one while receive buffer holds valid data.
// - Line status reads 0x6 after reset.
// - Error bit 3 is set on received break.
// - Error bit 2 is set on framing error.
// - Error bit 1 is set on parity error.
// - Reading the error register clears all four error flags.
// - Control bit 7 enables timeout interrupt, only in FIFO mode with dma_rx_mode set.
// - Control bit 6 enables the receive error interrupt.
// - Each channel has 16-byte transmit and receive FIFOs.
module ufs_top #(
   parameter int CHANNEL    = 0,
   parameter int FIFO_DEPTH = 16,
   parameter int DATA_WIDTH = 8
) (
   // Clock and reset.
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   // Register port.
   input  wire ufs_pkg::ufs_bus_req_type bus_req,
   output logic [31:0]                  bus_rdata,
   // Receive shifter side.
   input  wire ufs_pkg::ufs_rx_event_type rx_event,
   input  wire logic [DATA_WIDTH-1:0]   rx_char,
   input  wire logic                    char_time_tick,
   input  wire logic                    dma_rx_mode,
   // Data register side.
   input  wire logic                    tx_write,
   input  wire logic [DATA_WIDTH-1:0]   tx_write_data,
   input  wire logic                    rx_read,
   output logic [DATA_WIDTH-1:0]        rx_read_data,
   // Transmit shifter side.
   input  wire logic                    tx_shifter_busy,
   input  wire logic                    tx_take,
   output logic                         tx_char_valid,
   output logic [DATA_WIDTH-1:0]        tx_char,
   // Handshake pins.
   input  wire logic                    clear_to_send_n,
   output logic                         request_to_send_n,
   // Requests to the interrupt and DMA logic.
   output logic                         rx_service_req,
   output logic                         tx_service_req,
   output logic                         rx_timeout_irq,
   output logic                         rx_error_irq
);

   localparam int CW = $clog2(FIFO_DEPTH + 1);
   localparam int PW = $clog2(FIFO_DEPTH);
   localparam logic [27:0] A_FCON = CHANNEL == 0 ? ufs_pkg::ADDR_FIFO_CONTROL_CH0
                                                 : ufs_pkg::ADDR_FIFO_CONTROL_CH1;
   localparam logic [27:0] A_MCON = CHANNEL == 0 ? ufs_pkg::ADDR_MODEM_CONTROL_CH0
                                                 : ufs_pkg::ADDR_MODEM_CONTROL_CH1;
   localparam logic [27:0] A_LSTAT = CHANNEL == 0 ? ufs_pkg::ADDR_LINE_STATUS_CH0
                                                  : ufs_pkg::ADDR_LINE_STATUS_CH1;
   localparam logic [27:0] A_RERR = CHANNEL == 0 ? ufs_pkg::ADDR_RECEIVE_ERROR_CH0
                                                 : ufs_pkg::ADDR_RECEIVE_ERROR_CH1;
   localparam logic [27:0] A_FILL = CHANNEL == 0 ? ufs_pkg::ADDR_FILL_STATUS_CH0
                                                 : ufs_pkg::ADDR_FILL_STATUS_CH1;
   localparam logic [27:0] A_CCON = CHANNEL == 0 ? ufs_pkg::ADDR_CHANNEL_CONTROL_CH0
                                                 : ufs_pkg::ADDR_CHANNEL_CONTROL_CH1;

   logic [7:0]            fifo_control;
   logic [7:0]            modem_control;
   logic [7:0]            channel_control;
   logic [3:0]            receive_error;
   logic [DATA_WIDTH-1:0] tx_mem [FIFO_DEPTH];
   logic [DATA_WIDTH-1:0] rx_mem [FIFO_DEPTH];
   logic [PW-1:0]         tx_wr_ptr;
   logic [PW-1:0]         tx_rd_ptr;
   logic [PW-1:0]         rx_wr_ptr;
   logic [PW-1:0]         rx_rd_ptr;
   logic [CW-1:0]         tx_count;
   logic [CW-1:0]         rx_count;
   logic [CW-1:0]         tx_trigger;
   logic [CW-1:0]         rx_trigger;
   logic [CW-1:0]         tx_cap;
   logic [CW-1:0]         rx_cap;
   logic [1:0]            timeout_count;
   logic                  fifo_on;
   logic                  auto_flow;
   logic                  wr_fcon;
   logic                  rd_rerr;
   logic                  tx_push;
   logic                  tx_pop;
   logic                  rx_push;
   logic                  rx_pop;
   logic                  rx_overrun;
   logic                  tx_flush;
   logic                  rx_flush;

   ////////////////////////////////////////////////////////////////////////////
   // Decode and control fields.
   assign fifo_on   = fifo_control[ufs_pkg::FCON_ENABLE];
   assign auto_flow = modem_control[ufs_pkg::MCON_AUTO_FLOW];
   assign wr_fcon   = bus_req.write && bus_req.addr == A_FCON;
   assign rd_rerr   = bus_req.read && bus_req.addr == A_RERR;
   // Flush requests act on the write itself; the stored bit is seen set for one cycle.
   assign tx_flush  = wr_fcon && bus_req.wdata[ufs_pkg::FCON_TX_RESET];
   assign rx_flush  = wr_fcon && bus_req.wdata[ufs_pkg::FCON_RX_RESET];
   // Without FIFO mode each side holds a single byte.
   assign tx_cap    = fifo_on ? CW'(FIFO_DEPTH) : CW'(1);
   assign rx_cap    = fifo_on ? CW'(FIFO_DEPTH) : CW'(1);

   // Trigger decode.
   always_comb begin
      case (fifo_control[ufs_pkg::FCON_TX_TRIG_LSB +: 2])
         2'h0:    tx_trigger = CW'(0);
         2'h1:    tx_trigger = CW'(4);
         2'h2:    tx_trigger = CW'(8);
         default: tx_trigger = CW'(12);
      endcase
      case (fifo_control[ufs_pkg::FCON_RX_TRIG_LSB +: 2])
         2'h0:    rx_trigger = CW'(4);
         2'h1:    rx_trigger = CW'(8);
         2'h2:    rx_trigger = CW'(12);
         default: rx_trigger = CW'(16);
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers; reset bits clear themselves one cycle later.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fifo_control <= ufs_pkg::RESET_FIFO_CONTROL;
      end else if (wr_fcon) begin
         fifo_control <= bus_req.wdata[7:0] & ufs_pkg::FCON_WRITE_MASK;
      end else begin
         fifo_control[ufs_pkg::FCON_TX_RESET] <= 1'b0;
         fifo_control[ufs_pkg::FCON_RX_RESET] <= 1'b0;
      end
   end

   // Modem control keeps only its defined bits.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         modem_control <= ufs_pkg::RESET_MODEM_CONTROL;
      end else if (bus_req.write && bus_req.addr == A_MCON) begin
         modem_control <= bus_req.wdata[7:0] & ufs_pkg::MCON_WRITE_MASK;
      end
   end

   // Only the two interrupt enables of the channel control live here.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         channel_control <= ufs_pkg::RESET_CHANNEL_CONTROL;
      end else if (bus_req.write && bus_req.addr == A_CCON) begin
         channel_control <= bus_req.wdata[7:0] & 8'hC0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit FIFO; a flush overrides any push or pop in the same cycle.
   assign tx_push       = tx_write && tx_count < tx_cap;
   assign tx_char_valid = tx_count != CW'(0) && (!auto_flow || !clear_to_send_n);
   assign tx_pop        = tx_take && tx_char_valid;
   assign tx_char       = tx_mem[tx_rd_ptr];

   always_ff @(posedge mclk) begin
      if (!rst_n || tx_flush) begin
         tx_wr_ptr <= '0;
         tx_rd_ptr <= '0;
         tx_count  <= '0;
      end else begin
         if (tx_push) begin
            tx_wr_ptr <= PW'(tx_wr_ptr + 1'b1);
         end
         if (tx_pop) begin
            tx_rd_ptr <= PW'(tx_rd_ptr + 1'b1);
         end
         tx_count <= CW'(tx_count + CW'(tx_push) - CW'(tx_pop));
      end
   end

   // Storage write is kept apart from the pointers so memory needs no reset.
   always_ff @(posedge mclk) begin
      if (tx_push) begin
         tx_mem[tx_wr_ptr] <= tx_write_data;
      end
      if (rx_push) begin
         rx_mem[rx_wr_ptr] <= rx_char;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive FIFO; a full buffer drops the new character and flags overrun.
   assign rx_push      = rx_event.valid && rx_count < rx_cap;
   assign rx_overrun   = rx_event.valid && rx_count >= rx_cap;
   assign rx_pop       = rx_read && rx_count != CW'(0);
   assign rx_read_data = rx_mem[rx_rd_ptr];

   always_ff @(posedge mclk) begin
      if (!rst_n || rx_flush) begin
         rx_wr_ptr <= '0;
         rx_rd_ptr <= '0;
         rx_count  <= '0;
      end else begin
         if (rx_push) begin
            rx_wr_ptr <= PW'(rx_wr_ptr + 1'b1);
         end
         if (rx_pop) begin
            rx_rd_ptr <= PW'(rx_rd_ptr + 1'b1);
         end
         rx_count <= CW'(rx_count + CW'(rx_push) - CW'(rx_pop));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error flags: a new event in the read cycle survives the clear.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         receive_error <= ufs_pkg::RESET_RECEIVE_ERROR;
      end else begin
         receive_error <= (rd_rerr ? 4'h0 : receive_error)
                          | {rx_event.valid && rx_event.brk,
                             rx_event.valid && rx_event.frame_err,
                             rx_event.valid && rx_event.parity_err,
                             rx_overrun};
      end
   end

   assign rx_error_irq = channel_control[ufs_pkg::CCON_ERROR_EN] && receive_error != 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Receive timeout: counts idle character times while data sits below trigger.
   // A flush restarts it too, or a stale count would hold the interrupt after emptying.
   always_ff @(posedge mclk) begin
      if (!rst_n || rx_event.valid || rx_pop || rx_count == CW'(0)
          || rx_count >= rx_trigger || rx_flush) begin
         timeout_count <= 2'h0;
      end else if (char_time_tick && timeout_count != 2'(ufs_pkg::RX_TIMEOUT_CHARS)) begin
         timeout_count <= 2'(timeout_count + 1'b1);
      end
   end

   // Held as a level until data moves or new data arrives.
   assign rx_timeout_irq = fifo_on && dma_rx_mode
                           && channel_control[ufs_pkg::CCON_TIMEOUT_EN]
                           && timeout_count == 2'(ufs_pkg::RX_TIMEOUT_CHARS);

   ////////////////////////////////////////////////////////////////////////////
   // Service requests and flow control.
   assign rx_service_req = fifo_on ? rx_count >= rx_trigger
                                   : rx_count != CW'(0);
   assign tx_service_req = fifo_on ? tx_count <= tx_trigger : tx_count == CW'(0);

   // Stop the partner with a little headroom for a character already in flight.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         request_to_send_n <= 1'b1;
      end else if (auto_flow) begin
         request_to_send_n <= rx_count + CW'(ufs_pkg::FLOW_HEADROOM) > rx_cap;
      end else begin
         request_to_send_n <= !modem_control[ufs_pkg::MCON_RTS];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the read strobe; unmapped reads give zero.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bus_rdata <= 32'h0000_0000;
      end else if (!bus_req.read) begin
         bus_rdata <= 32'h0000_0000;
      end else begin
         case (bus_req.addr)
            A_FCON:  bus_rdata <= {24'h000000, fifo_control};
            A_MCON:  bus_rdata <= {24'h000000, modem_control};
            A_CCON:  bus_rdata <= {24'h000000, channel_control};
            A_LSTAT: bus_rdata <= {29'h0, tx_count == CW'(0) && !tx_shifter_busy,
                                   tx_count == CW'(0),
                                   rx_count != CW'(0)};
            A_RERR:  bus_rdata <= {28'h0000000, receive_error};
            A_FILL:  bus_rdata <= {22'h0, tx_count == CW'(FIFO_DEPTH), rx_count == CW'(FIFO_DEPTH),
                                   tx_count[3:0], rx_count[3:0]};
            default: bus_rdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule : ufs_top

// ==== core/ufs_pkg.sv ====
// Package for the per-channel FIFO, flow control and status register block.
package ufs_pkg;

   // Register byte addresses, channel 0 and channel 1.
   localparam logic [27:0] ADDR_FIFO_CONTROL_CH0   = 28'h1D00008;
   localparam logic [27:0] ADDR_MODEM_CONTROL_CH0  = 28'h1D0000C;
   localparam logic [27:0] ADDR_LINE_STATUS_CH0    = 28'h1D00010;
   localparam logic [27:0] ADDR_RECEIVE_ERROR_CH0  = 28'h1D00014;
   localparam logic [27:0] ADDR_FILL_STATUS_CH0    = 28'h1D00018;
   localparam logic [27:0] ADDR_CHANNEL_CONTROL_CH0 = 28'h1D00004;
   localparam logic [27:0] ADDR_FIFO_CONTROL_CH1   = 28'h1D04008;
   localparam logic [27:0] ADDR_MODEM_CONTROL_CH1  = 28'h1D0400C;
   localparam logic [27:0] ADDR_LINE_STATUS_CH1    = 28'h1D04010;
   localparam logic [27:0] ADDR_RECEIVE_ERROR_CH1  = 28'h1D04014;
   localparam logic [27:0] ADDR_FILL_STATUS_CH1    = 28'h1D04018;
   localparam logic [27:0] ADDR_CHANNEL_CONTROL_CH1 = 28'h1D04004;

   // Field positions.
   localparam int FCON_TX_TRIG_LSB = 6;
   localparam int FCON_RX_TRIG_LSB = 4;
   localparam int FCON_TX_RESET    = 2;
   localparam int FCON_RX_RESET    = 1;
   localparam int FCON_ENABLE      = 0;
   localparam int MCON_AUTO_FLOW   = 4;
   localparam int MCON_RTS         = 0;
   localparam int CCON_TIMEOUT_EN  = 7;
   localparam int CCON_ERROR_EN    = 6;

   // Reset values.
   localparam logic [7:0] RESET_FIFO_CONTROL    = 8'h00;
   localparam logic [7:0] RESET_MODEM_CONTROL   = 8'h00;
   localparam logic [7:0] RESET_CHANNEL_CONTROL = 8'h00;
   localparam logic [2:0] RESET_LINE_STATUS     = 3'h6;
   localparam logic [3:0] RESET_RECEIVE_ERROR   = 4'h0;

   // Writable masks; reserved bit 3 of the FIFO control stays zero.
   localparam logic [7:0] FCON_WRITE_MASK = 8'hF7;
   localparam logic [7:0] MCON_WRITE_MASK = 8'h11;

   // Timeout length in character times and flow-control headroom.
   localparam int RX_TIMEOUT_CHARS = 3;
   localparam int FLOW_HEADROOM    = 2;

   // Register-bus request carrier.
   typedef struct packed {
      logic [27:0] addr;
      logic [31:0] wdata;
      logic        write;
      logic        read;
   } ufs_bus_req_type;

   // Received-character event carrier from the receive shifter.
   typedef struct packed {
      logic valid;
      logic brk;
      logic frame_err;
      logic parity_err;
   } ufs_rx_event_type;

endpackage : ufs_pkg

// ==== sim/ufs_monitor.sv ====
// Port-level checks for one channel of the serial control block.
module ufs_monitor (
   // Clock and reset.
   input wire logic                      mclk,
   input wire logic                      rst_n,
   // Register port.
   input wire ufs_pkg::ufs_bus_req_type  bus_req,
   input wire logic [31:0]               bus_rdata,
   // Data sides and handshake.
   input wire ufs_pkg::ufs_rx_event_type rx_event,
   input wire logic                      dma_rx_mode,
   input wire logic                      tx_take,
   input wire logic                      tx_shifter_busy,
   input wire logic                      tx_char_valid,
   input wire logic                      clear_to_send_n,
   input wire logic                      request_to_send_n,
   // Requests.
   input wire logic                      rx_service_req,
   input wire logic                      tx_service_req,
   input wire logic                      rx_timeout_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic rd_err, rd_ls, rd_fc, wr_fc, wr_mc;
   // Strobe decode; only the channel 0 address set is watched.
   assign rd_err = bus_req.read && bus_req.addr == ufs_pkg::ADDR_RECEIVE_ERROR_CH0;
   assign rd_ls  = bus_req.read && bus_req.addr == ufs_pkg::ADDR_LINE_STATUS_CH0;
   assign rd_fc  = bus_req.read && bus_req.addr == ufs_pkg::ADDR_FIFO_CONTROL_CH0;
   assign wr_fc  = bus_req.write && bus_req.addr == ufs_pkg::ADDR_FIFO_CONTROL_CH0;
   assign wr_mc  = bus_req.write && bus_req.addr == ufs_pkg::ADDR_MODEM_CONTROL_CH0;
   ////////////////////////////////////////////////////////////////////////////////
   a_err_read_clear: assert property ((rd_err && !rx_event.valid ##1
      !rx_event.valid ##1 rd_err && !rx_event.valid) |=> bus_rdata[3:0] == 4'h0)
      else $error("flags kept");
   a_rts_software: assert property (wr_mc && !bus_req.wdata[4] |=>
      ##1 request_to_send_n == !$past(bus_req.wdata[0], 2)) else $error("rts level");
   a_flush_rx: assert property (wr_fc && bus_req.wdata[1] && !rx_event.valid |=>
      !rx_service_req && !rx_timeout_irq) else $error("rx flush");
   a_flush_tx: assert property (wr_fc && bus_req.wdata[2] |=> !tx_char_valid)
      else $error("tx flush");
   // The reset bits stay visible for the one cycle right after the write itself.
   a_fcon_selfclear: assert property (rd_fc && !$past(wr_fc)
      |=> bus_rdata[3:1] == 3'h0) else $error("reset bits read back");
   a_rx_ready: assert property (rd_ls && rx_service_req |=> bus_rdata[0])
      else $error("rx ready low");
   a_shift_busy: assert property (rd_ls && tx_shifter_busy |=> !bus_rdata[2])
      else $error("shifter shown empty");
   a_tx_pending: assert property (rd_ls && tx_char_valid && !tx_take
      |=> !bus_rdata[1]) else $error("holding shown empty");
   a_timeout_dma: assert property (!dma_rx_mode |-> !rx_timeout_irq)
      else $error("timeout outside dma");
   a_tx_req_empty: assert property (!tx_char_valid && !clear_to_send_n
      |-> tx_service_req) else $error("tx request low");
   // Main scenarios reached.
   c_overrun: cover property (rd_err ##1 bus_rdata[0]);
   c_trigger: cover property ($rose(rx_service_req));
   c_timeout: cover property ($rose(rx_timeout_irq));
endmodule : ufs_monitor

bind ufs_top ufs_monitor i_monitor (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req),
   .bus_rdata(bus_rdata), .rx_event(rx_event), .dma_rx_mode(dma_rx_mode), .tx_take(tx_take),
   .tx_shifter_busy(tx_shifter_busy), .tx_char_valid(tx_char_valid),
   .clear_to_send_n(clear_to_send_n), .request_to_send_n(request_to_send_n),
   .rx_service_req(rx_service_req), .tx_service_req(tx_service_req),
   .rx_timeout_irq(rx_timeout_irq));

// ==== sim/ufs_partner.sv ====
// Far-side serial device: drives the clear-to-send line of the channel.
module ufs_partner (
   // Clock and reset.
   input  wire logic mclk,
   input  wire logic rst_n,
   // Bench command: the far side is slow and not ready.
   input  wire logic stall,
   // Handshake line.
   output logic      clear_to_send_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // Readiness is granted one cycle after the far side can take data; not ready in reset.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         clear_to_send_n <= 1'b1;
      end else begin
         clear_to_send_n <= stall;
      end
   end
endmodule : ufs_partner

// ==== sim/test_ufs_top.sv ====
// Self-checking bench for one channel of the serial control block.
module test_ufs_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [27:0] FC = ufs_pkg::ADDR_FIFO_CONTROL_CH0;
   localparam logic [27:0] MC = ufs_pkg::ADDR_MODEM_CONTROL_CH0;
   localparam logic [27:0] LS = ufs_pkg::ADDR_LINE_STATUS_CH0;
   localparam logic [27:0] ER = ufs_pkg::ADDR_RECEIVE_ERROR_CH0;
   localparam logic [27:0] FS = ufs_pkg::ADDR_FILL_STATUS_CH0;
   localparam logic [27:0] CC = ufs_pkg::ADDR_CHANNEL_CONTROL_CH0;
   ufs_pkg::ufs_bus_req_type  req = '0;
   ufs_pkg::ufs_rx_event_type ev = '0;
   logic mclk = 1'b0, rst_n = 1'b0, tick = 1'b0, dma = 1'b0, txw = 1'b0, rxr = 1'b0;
   logic busy = 1'b0, take = 1'b0, stall = 1'b0;
   logic txv, rts_n, cts_n, rreq, treq, tirq, eirq;
   logic [7:0]  rxc = 8'h00, txd = 8'h00, rxq, txc;
   logic [31:0] rdata, seed = 32'h40DB933C;
   logic [3:0]  em = 4'h0;
   logic [7:0]  q[$], tq[$];
   int          errors = 0, checked = 0, cap = 1, k;
   ufs_top #(.CHANNEL(0)) i_dut (.mclk(mclk), .rst_n(rst_n), .bus_req(req), .bus_rdata(rdata),
      .rx_event(ev), .rx_char(rxc), .char_time_tick(tick), .dma_rx_mode(dma), .tx_write(txw),
      .tx_write_data(txd), .rx_read(rxr), .rx_read_data(rxq), .tx_shifter_busy(busy),
      .tx_take(take), .tx_char_valid(txv), .tx_char(txc), .clear_to_send_n(cts_n),
      .request_to_send_n(rts_n), .rx_service_req(rreq), .tx_service_req(treq),
      .rx_timeout_irq(tirq), .rx_error_irq(eirq));
   ufs_partner i_far (.mclk(mclk), .rst_n(rst_n), .stall(stall), .clear_to_send_n(cts_n));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results;
      if (errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results
   // Bus cycles hold every signal from one rising edge to the next.
   task automatic wr(input logic [27:0] a, input logic [7:0] v);
      @(posedge mclk);
      req <= '{a, {24'h0, v}, 1'b1, 1'b0};
      @(posedge mclk);
      req.write <= 1'b0;
      #1;
   endtask : wr
   task automatic rc(input logic [27:0] a, input logic [31:0] exp);
      @(posedge mclk);
      req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge mclk);
      req.read <= 1'b0;
      #1 check(rdata, exp);
   endtask : rc
   // Reading the flags empties the model too.
   task automatic rerr;
      rc(ER, {28'h0, em});
      em = 4'h0;
   endtask : rerr
   // A character arrives; the model drops it and marks an overrun when full.
   task automatic rx(input logic [3:0] f);
      @(posedge mclk);
      seed = lfsr(seed);
      ev <= f;
      rxc <= seed[7:0];
      if (q.size() < cap) q.push_back(seed[7:0]);
      else em[0] = 1'b1;
      em[3:1] = em[3:1] | f[2:0];
      @(posedge mclk);
      ev <= '0;
      #1;
   endtask : rx
   task automatic pop;
      @(posedge mclk);
      rxr <= 1'b1;
      #1 check(32'(rxq), 32'(q.pop_front()));
      @(posedge mclk);
      rxr <= 1'b0;
      #1;
   endtask : pop
   task automatic txpush;
      @(posedge mclk);
      seed = lfsr(seed);
      txw <= 1'b1;
      txd <= seed[7:0];
      tq.push_back(seed[7:0]);
      @(posedge mclk);
      txw <= 1'b0;
      #1;
   endtask : txpush
   task automatic tk;
      @(posedge mclk);
      tick <= 1'b1;
      @(posedge mclk);
      tick <= 1'b0;
      #1;
   endtask : tk
   task automatic settle;
      @(posedge mclk);
      #1;
   endtask : settle
   ////////////////////////////////////////////////////////////////////////////////
   // Clock and a watchdog so that a hang still ends in the verdict.
   initial begin
      forever #20 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      results;
   end
   initial begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      rc(FC, 32'h0);
      rc(MC, 32'h0);
      rc(LS, 32'h6);
      rerr;
      rc(28'h1D00030, 32'h0);
      check(32'(rts_n), 32'h1);
      // Single holding registers: status bits, overrun and error flags.
      wr(CC, 8'h40);
      txpush;
      rc(LS, 32'h0);
      check(32'(txc), 32'(tq[0]));
      @(posedge mclk);
      busy <= 1'b1;
      take <= 1'b1;
      @(posedge mclk);
      take <= 1'b0;
      rc(LS, 32'h2);
      @(posedge mclk);
      busy <= 1'b0;
      rx(4'h8);
      rx(4'h8);
      rc(LS, 32'h7);
      rerr;
      rerr;
      pop;
      for (k = 0; k < 3; k++) begin
         rx(4'h8 | (4'h4 >> k));
         check(32'(eirq), 32'h1);
         pop;
         rerr;
      end
      // Receive trigger levels and service requests, FIFO mode.
      cap = 16;
      for (k = 0; k < 4; k++) begin
         wr(FC, {2'b00, 2'(k), 4'h3});
         rc(FC, {26'h0, 2'(k), 4'h1});
         repeat (4 * k + 3) rx(4'h8);
         check(32'(rreq), 32'h0);
         rx(4'h8);
         check(32'(rreq), 32'h1);
         rc(LS, 32'h7);
         repeat (4 * k + 4) pop;
      end
      // Transmit trigger levels, then a transmit flush.
      for (k = 0; k < 4; k++) begin
         wr(FC, {2'(k), 6'h05});
         tq.delete();
         repeat (4 * k) txpush;
         check(32'(treq), 32'h1);
         txpush;
         check(32'(treq), 32'h0);
      end
      wr(FC, 8'h05);
      tq.delete();
      check(32'(txv), 32'h0);
      // Flow control: automatic on a filling receive FIFO and a stalled partner, then request-to-send by software.
      wr(MC, 8'h11);
      repeat (14) rx(4'h8);
      check(32'(rts_n), 32'h0);
      rx(4'h8);
      settle;
      check(32'(rts_n), 32'h1);
      rx(4'h8);
      rx(4'h8);
      rc(FS, {22'h0, 1'b0, q.size() == 16, 4'h0, 4'(q.size())});
      rerr;
      repeat (16) pop;
      wr(MC, 8'h10);
      settle;
      check(32'(rts_n), 32'h0);
      @(posedge mclk);
      stall <= 1'b1;
      txpush;
      check(32'(txv), 32'h0);
      @(posedge mclk);
      stall <= 1'b0;
      settle;
      check(32'(txv), 32'h1);
      check(32'(txc), 32'(tq[0]));
      wr(MC, 8'h01);
      settle;
      check(32'(rts_n), 32'h0);
      wr(MC, 8'h00);
      settle;
      check(32'(rts_n), 32'h1);
      // Receive timeout in DMA mode below the trigger level; error interrupt masked.
      wr(CC, 8'h80);
      wr(FC, 8'h03);
      @(posedge mclk);
      dma <= 1'b1;
      rx(4'hC);
      check(32'(eirq), 32'h0);
      repeat (2) tk;
      check(32'(tirq), 32'h0);
      tk;
      check(32'(tirq), 32'h1);
      rc(FS, {24'h0, 4'(tq.size()), 4'(q.size())});
      wr(CC, 8'h00);
      check(32'(tirq), 32'h0);
      wr(CC, 8'h80);
      check(32'(tirq), 32'h1);
      pop;
      check(32'(tirq), 32'h0);
      rerr;
      @(posedge mclk);
      dma <= 1'b0;
      results;
   end
endmodule : test_ufs_top
